// *** asc_consts.vh ***
// Constants for the asynchronous byte-wide static RAM host controller
// Assumes a 250 MHz system clock, 4 ns period
`ifndef ASC_CONSTS_VH
`define ASC_CONSTS_VH

// ==========================================
// Geometry
`define ASC_ADDR_W        15
`define ASC_DATA_W        8

// ==========================================
// Timing in ns and clock rate
`define ASC_CLK_PERIOD_NS 4
`define ASC_T_CYCLE_NS    70
`define ASC_T_ACCESS_NS   70
`define ASC_T_WPULSE_NS   40
`define ASC_T_TURN_NS     35
`define ASC_T_RECOV_NS    70

// ==========================================
// Cycle counts, least times rounded up
`define ASC_CYC(ns)       (((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_ACCESS_CYC    `ASC_CYC(`ASC_T_ACCESS_NS)
`define ASC_WPULSE_CYC    `ASC_CYC(`ASC_T_WPULSE_NS)
`define ASC_TURN_CYC      `ASC_CYC(`ASC_T_TURN_NS)
`define ASC_RECOV_CYC     `ASC_CYC(`ASC_T_RECOV_NS)
`define ASC_CYCLE_CYC     `ASC_CYC(`ASC_T_CYCLE_NS)

`endif

// *** asc_timer.v ***
// Down-counter that times each phase of a memory access
// Assumes load and value come from the host sequencer in the same clock domain
`timescale 1ns/1ps

module asc_timer #(
  parameter W = 6
) (
  // Clock and reset
  input  wire         clock,
  input  wire         arst_n,
  // Control
  input  wire         load,
  input  wire [W-1:0] value,
  // Status
  output wire         done
);

  reg [W-1:0] cnt_r;
  reg [W-1:0] cnt_nxt;

  // ==========================================
  // Counter
  always @* begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = value;
    end else if (cnt_r != {W{1'b0}}) begin
      cnt_nxt = cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= {W{1'b0}};
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done = (cnt_r == {W{1'b0}});

endmodule // asc_timer

// *** asc_host.v ***
// Host controller driving an asynchronous 32K x 8 static RAM over its pins
// Assumes the RAM pins are wired straight out; data lines resolved outside
// Function
// - Host holds chip select low through each whole read or write.
// - Eight two-way data lines; each side drives only its own direction.
// - Host keeps every don't-care strobe at a valid high or low.
// - Host deasserts chip select before and throughout low-supply retention.
`timescale 1ns/1ps
`include "asc_consts.vh"

module asc_host #(
  parameter ADDR_W = `ASC_ADDR_W,
  parameter DATA_W = `ASC_DATA_W
) (
  // Clock and reset
  input  wire              clock,
  input  wire              arst_n,
  // User request
  input  wire              req_valid,
  output wire              req_ready,
  input  wire              req_write,
  input  wire [ADDR_W-1:0] req_addr,
  input  wire [DATA_W-1:0] req_wdata,
  // User answer
  output reg               rsp_valid,
  output reg  [DATA_W-1:0] rsp_rdata,
  // Retention control
  input  wire              retain_req,
  output wire              retain_ok,
  // Memory pins
  output reg  [ADDR_W-1:0] addr_lines,
  output reg               chip_sel_n,
  output reg               write_n,
  output reg               out_drive_n,
  input  wire [DATA_W-1:0] data_lines_in,
  output reg  [DATA_W-1:0] data_lines_out,
  output reg               data_lines_oe
);

  // ==========================================
  // States
  localparam [2:0] ST_IDLE   = 3'd0;
  localparam [2:0] ST_RD     = 3'd1;
  localparam [2:0] ST_WR     = 3'd2;
  localparam [2:0] ST_TURN   = 3'd3;
  localparam [2:0] ST_RECOV  = 3'd4;
  localparam [2:0] ST_RETAIN = 3'd5;

  // ==========================================
  // Timing counts, cut to the timer width
  localparam integer TW = 6;
  localparam integer ACCESS_N = `ASC_ACCESS_CYC;
  localparam integer WPULSE_N = `ASC_CYCLE_CYC;
  localparam integer TURN_N   = `ASC_TURN_CYC;
  localparam integer RECOV_N  = `ASC_RECOV_CYC;

  localparam [TW-1:0] ACCESS_CYC = ACCESS_N[TW-1:0];
  localparam [TW-1:0] WPULSE_CYC = WPULSE_N[TW-1:0];
  localparam [TW-1:0] TURN_CYC   = TURN_N[TW-1:0];
  localparam [TW-1:0] RECOV_CYC  = RECOV_N[TW-1:0];

  reg [2:0]    st_r;
  reg [2:0]    st_nxt;
  reg          ld;
  reg [TW-1:0] ld_val;
  wire         t_done;
  wire         take;

  // ==========================================
  // Request decode
  function take_fn;
    input [2:0] st;
    input       valid;
    input       retain;
    begin
      take_fn = (st == ST_IDLE) && valid && !retain;
    end
  endfunction

  assign take = take_fn(st_r, req_valid, retain_req);

  asc_timer #(
    .W (TW)
  ) u_timer (
    .clock  (clock),
    .arst_n (arst_n),
    .load   (ld),
    .value  (ld_val),
    .done   (t_done)
  );

  assign req_ready = take_fn(st_r, 1'b1, retain_req);
  assign retain_ok = (st_r == ST_RETAIN);

  // ==========================================
  // Sequencer
  always @* begin
    st_nxt = st_r;
    ld     = 1'b0;
    ld_val = {TW{1'b0}};
    case (st_r)
      ST_IDLE: begin
        if (retain_req) begin
          st_nxt = ST_RETAIN;
        end else if (req_valid) begin
          ld     = 1'b1;
          ld_val = req_write ? WPULSE_CYC : ACCESS_CYC;
          st_nxt = req_write ? ST_WR : ST_RD;
        end
      end
      ST_RD: begin
        if (t_done) begin
          ld     = 1'b1;
          ld_val = TURN_CYC;
          st_nxt = ST_TURN;
        end
      end
      ST_WR: begin
        if (t_done) begin
          ld     = 1'b1;
          ld_val = RECOV_CYC;
          st_nxt = ST_RECOV;
        end
      end
      ST_TURN: begin
        if (t_done) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_RECOV: begin
        if (t_done) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_RETAIN: begin
        if (!retain_req) begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // ==========================================
  // Pin drivers
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r           <= ST_IDLE;
      addr_lines     <= {ADDR_W{1'b0}};
      chip_sel_n     <= 1'b1;
      write_n        <= 1'b1;
      out_drive_n    <= 1'b1;
      data_lines_out <= {DATA_W{1'b0}};
      data_lines_oe  <= 1'b0;
      rsp_valid      <= 1'b0;
      rsp_rdata      <= {DATA_W{1'b0}};
    end else begin
      st_r      <= st_nxt;
      rsp_valid <= 1'b0;
      case (st_nxt)
        ST_RD: begin
          chip_sel_n  <= 1'b0;
          write_n     <= 1'b1;
          out_drive_n <= 1'b0;
          data_lines_oe <= 1'b0;
        end
        ST_WR: begin
          chip_sel_n    <= 1'b0;
          write_n       <= 1'b0;
          out_drive_n   <= 1'b1;
          data_lines_oe <= 1'b1;
        end
        ST_RETAIN: begin
          chip_sel_n    <= 1'b1;
          write_n       <= 1'b1;
          out_drive_n   <= 1'b1;
          data_lines_oe <= 1'b0;
        end
        ST_TURN: begin
          chip_sel_n    <= 1'b1;
          write_n       <= 1'b1;
          out_drive_n   <= 1'b1;
          data_lines_oe <= 1'b0;
        end
        default: begin
          chip_sel_n    <= 1'b1;
          write_n       <= 1'b1;
          out_drive_n   <= 1'b1;
          data_lines_oe <= 1'b0;
        end
      endcase
      if (take) begin
        addr_lines     <= req_addr;
        data_lines_out <= req_wdata;
      end
      if (st_r == ST_RD && t_done) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= data_lines_in;
      end
    end
  end

endmodule // asc_host

// *** asc_sram_mdl.sv ***
// Behavioural 32K x 8 static RAM at the controller pins
// Assumes the bench feeds the host drive; resolves the data wire
`timescale 1ns/1ps
module asc_sram_mdl (
  // Clock for the idle pattern
  input  wire        clock,
  // Pins
  input  wire [14:0] addr_lines,
  input  wire        chip_sel_n,
  input  wire        write_n,
  input  wire        out_drive_n,
  input  wire [7:0]  host_d,
  input  wire        host_oe,
  // Resolved wire
  output reg  [7:0]  data_lines
);
  reg  [7:0] mem [0:32767];
  reg        flip = 1'b0;
  wire       rd = !chip_sel_n && write_n && !out_drive_n;
  always @(posedge clock) flip <= ~flip;
  always @* begin
    if (host_oe)
      data_lines = host_d;
    else if (rd)
      data_lines = mem[addr_lines];
    else
      data_lines = {8{flip}} ^ 8'h5a;
    if (!chip_sel_n && !write_n)
      mem[addr_lines] = data_lines;
  end
endmodule // asc_sram_mdl

// *** asc_host_asserts.sv ***
// Pin protocol checks on the controller
// Assumes bind onto asc_host
`timescale 1ns/1ps
module asc_host_chk (
  input wire clock,
  input wire arst_n,
  input wire chip_sel_n,
  input wire write_n,
  input wire out_drive_n,
  input wire data_lines_oe,
  input wire retain_ok
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_held;
    !chip_sel_n [*8];
  endsequence
  property p_sel_hold; $fell(chip_sel_n) |-> s_held; endproperty
  property p_wr_sel; !write_n || !out_drive_n |-> !chip_sel_n; endproperty
  property p_drive; data_lines_oe |-> !chip_sel_n && !write_n; endproperty
  property p_retain; retain_ok |-> chip_sel_n && write_n; endproperty
  property p_clash; !chip_sel_n && !out_drive_n |-> !data_lines_oe; endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select dropped early");
  a_wr_sel: assert property (p_wr_sel) else $error("strobe without select");
  a_drive: assert property (p_drive) else $error("host drives outside write");
  a_retain: assert property (p_retain) else $error("select in retention");
  a_clash: assert property (p_clash) else $error("drive clash");
endmodule // asc_host_chk
bind asc_host asc_host_chk i_chk (.clock, .arst_n, .chip_sel_n, .write_n, .out_drive_n,
  .data_lines_oe, .retain_ok);

// *** tb_asc_host.sv ***
// Self-checking bench for the static RAM controller
// Assumes asc_host, asc_sram_mdl and the checker are compiled first
`timescale 1ns/1ps
`include "asc_consts.vh"
module tb_asc_host;
  reg         clock = 0, arst_n = 0, req_valid = 0, req_write = 0, retain_req = 0;
  reg  [14:0] req_addr = 0;
  reg  [7:0]  req_wdata = 0;
  wire [14:0] addr_lines;
  wire [7:0]  rsp_rdata, dq, host_d;
  wire        req_ready, rsp_valid, retain_ok, chip_sel_n, write_n, out_drive_n, host_oe;
  reg  [7:0]  shadow [0:32767];
  reg  [14:0] ad [0:11];
  integer     miscompares = 0, samples_checked = 0, i, n;
  asc_host i_asc_host (.clock, .arst_n, .req_valid, .req_ready, .req_write, .req_addr,
    .req_wdata, .rsp_valid, .rsp_rdata, .retain_req, .retain_ok, .addr_lines, .chip_sel_n,
    .write_n, .out_drive_n, .data_lines_in(dq), .data_lines_out(host_d),
    .data_lines_oe(host_oe));
  asc_sram_mdl i_asc_sram_mdl (.clock, .addr_lines, .chip_sel_n, .write_n, .out_drive_n,
    .host_d, .host_oe, .data_lines(dq));
  initial forever #2 clock = ~clock;
  function [7:0] exp_rd(input [14:0] a);
    exp_rd = shadow[a];
  endfunction
  task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("Error %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task access(input w, input [14:0] a, input [7:0] d);
    begin
      req_valid = 1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      n = 0;
      while (!req_ready && n < 200) begin
        @(negedge clock);
        n = n + 1;
      end
      if (!req_ready) miscompares = miscompares + 1;
      @(negedge clock);
      req_valid = 0;
      n = 0;
      while (!w && !rsp_valid && n < 40) begin
        @(negedge clock);
        n = n + 1;
      end
      if (!w) check("read latency", n, `ASC_ACCESS_CYC + 1);
      if (!w) check("read data", rsp_rdata, exp_rd(a));
      if (w) shadow[a] = d;
      if (w) @(negedge clock);
    end
  endtask
  task end_of_test;
    begin
      $display("Checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    #60000;
    miscompares = miscompares + 1;
    end_of_test;
  end
  initial begin
    n = $urandom(32'he1156e13);
    repeat (10) @(negedge clock);
    arst_n = 1;
    for (i = 0; i < 12; i = i + 1) begin
      ad[i] = i < 2 ? {15{i[0]}} : $urandom;
      access(1, ad[i], i == 2 ? 8'hff : $urandom);
    end
    for (i = 0; i < 12; i = i + 1) access(0, ad[i], 0);
    $display("Test write and read done");
    retain_req = 1;
    repeat (60) @(negedge clock);
    check("retain", {retain_ok, req_ready, chip_sel_n}, 8'h05);
    retain_req = 0;
    access(0, ad[1], 0);
    $display("Test retention done");
    end_of_test;
  end
endmodule // tb_asc_host
